//--- logic/pims_bank.sv
// Purpose: interrupt mask, special control/status and indirect access registers
// Assumes: register port driven by the management frame engine on clk
// Notes: event inputs are one-cycle pulses from logic on the same clock
//
// Contract
// - eight mask bits 8:1, reset zero
// - mask bits 15:9 and 0 read-only
// - event flags latch until read
// - bit 12 shows negotiation done
// - bit 6 enables 4B5B, reset one
// - bits 4:2 show speed/duplex code
// - other special bits reserved read-only
// - indirect spaces only via control/data pair
// - decode devices 3, 7, 30 only
// - data register write latches pointer
// - data phase reads/writes pointed register
// - coding sublayer index map
// - negotiation index map
// - vendor index map
// - symbol error counter, once per packet
`timescale 1ns/1ps
module pims_bank
  import pims_pkg::*;
#(
  parameter int FLAG_W = 8 // number of interrupt sources
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [FLAG_W:1] src_event,
  input wire logic aneg_done,
  input wire logic [2:0] resolved_speed_duplex_code,
  input wire logic link_100,
  input wire logic rx_in_packet,
  input wire logic rx_symbol_error,
  output logic enc_4b5b_en,
  output logic irq
);
  pims_mmd_if mif ();

  logic [FLAG_W:1] mask_r, mask_nxt; // interrupt enable mask
  logic [FLAG_W:1] flag_r, flag_nxt; // latched event flags
  logic en4b5b_r, en4b5b_nxt; // encoder enable
  logic [15:0] ctrl_r, ctrl_nxt; // access control register
  logic [15:0] ptr_r, ptr_nxt; // pointer within the device
  logic [15:0] symerr_r, symerr_nxt; // symbol error count
  logic pkt_err_r, pkt_err_nxt; // error already counted in packet
  logic [15:0] rdata_r, rdata_nxt; // read answer
  logic rvalid_r; // read answer strobe
  logic irq_r, irq_nxt; // interrupt output
  logic [15:0] mask_word; // mask as read
  logic [15:0] flag_word; // flags as read
  logic [15:0] spc_word; // special control/status as read
  logic data_phase; // control holds the data function
  logic wr_data; // write strobe of the address/data register
  logic rd_flags; // read strobe of the flag register
  logic [4:0] devsel; // selected indirect device

  // true when the strobe aims at the given register index
  function automatic logic pims_at(input logic s, input logic [4:0] i, input logic [4:0] w);
    return s && (i == w);
  endfunction : pims_at

  // decode of access strobes
  assign data_phase = (ctrl_r[PIMS_CTRL_FN_LSB +: 2] == PIMS_FN_DATA);
  assign devsel = ctrl_r[4:0];
  assign wr_data = pims_at(reg_wr, reg_index, PIMS_IDX_MMD_DATA);
  assign rd_flags = pims_at(reg_rd, reg_index, PIMS_IDX_FLAGS);

  // indirect path through control and data
  assign mif.dev = devsel;
  assign mif.index = ptr_r;
  assign mif.wdata = reg_wdata;
  assign mif.we = wr_data && data_phase;

  pims_mmd_store u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .mif(mif)
  );

  assign mask_word = {{(15 - FLAG_W){1'b0}}, mask_r, 1'b0};
  assign flag_word = {{(15 - FLAG_W){1'b0}}, flag_r, 1'b0};
  always_comb begin
    spc_word = 16'h0000;
    spc_word[PIMS_SPC_DONE_BIT] = aneg_done;
    spc_word[PIMS_SPC_4B5B_BIT] = en4b5b_r;
    spc_word[PIMS_SPC_SPEED_LSB +: 3] = resolved_speed_duplex_code;
  end

  // register writes and event capture
  always_comb begin
    mask_nxt = mask_r;
    en4b5b_nxt = en4b5b_r;
    ctrl_nxt = ctrl_r;
    ptr_nxt = ptr_r;
    if (reg_wr) begin
      case (reg_index)
        PIMS_IDX_MASK: mask_nxt = reg_wdata[FLAG_W:1];
        PIMS_IDX_SPECIAL: en4b5b_nxt = reg_wdata[PIMS_SPC_4B5B_BIT];
        PIMS_IDX_MMD_CTRL: ctrl_nxt = reg_wdata;
        PIMS_IDX_MMD_DATA: if (!data_phase) ptr_nxt = reg_wdata;
        default: ;
      endcase
    end
    flag_nxt = (rd_flags ? '0 : flag_r) | src_event;
  end

  // read answer selection
  always_comb begin
    case (reg_index)
      PIMS_IDX_MASK: rdata_nxt = mask_word;
      PIMS_IDX_SPECIAL: rdata_nxt = spc_word;
      PIMS_IDX_FLAGS: rdata_nxt = flag_word;
      PIMS_IDX_SYM_ERR: rdata_nxt = symerr_r;
      PIMS_IDX_MMD_CTRL: rdata_nxt = ctrl_r;
      PIMS_IDX_MMD_DATA: rdata_nxt = data_phase ? mif.rdata : ptr_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // one count per packet, wraps, no read clear
  always_comb begin
    symerr_nxt = symerr_r;
    pkt_err_nxt = pkt_err_r && rx_in_packet;
    if (link_100 && rx_symbol_error && !pkt_err_r) begin
      symerr_nxt = symerr_r + 16'h0001;
      pkt_err_nxt = rx_in_packet;
    end
  end

  assign irq_nxt = |(flag_nxt & mask_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= PIMS_MASK_RST[FLAG_W:1];
      en4b5b_r <= PIMS_4B5B_RST;
    end else begin
      mask_r <= mask_nxt;
      en4b5b_r <= en4b5b_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= PIMS_CTRL_RST;
      ptr_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // symbol error count, cleared by reset only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      symerr_r <= 16'h0000;
      pkt_err_r <= 1'b0;
    end else begin
      symerr_r <= symerr_nxt;
      pkt_err_r <= pkt_err_nxt;
    end
  end

  // read answer, held until the next read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  // read answer strobe, one cycle after the read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign enc_4b5b_en = en4b5b_r;
  assign irq = irq_r;
endmodule : pims_bank

//--- logic/pims_mmd_if.sv
// Purpose: carries one indirect register access between bank and store
// Assumes: single clock, combinational read data
// Notes: write strobe is one cycle
`timescale 1ns/1ps
interface pims_mmd_if;
  logic [4:0] dev; // selected device number
  logic [15:0] index; // pointer within the device
  logic [15:0] wdata; // data to store
  logic we; // one-cycle write strobe
  logic [15:0] rdata; // contents of the pointed register
  logic hit; // device and index are implemented
  modport bank (output dev, output index, output wdata, output we, input rdata, input hit);
  modport store (input dev, input index, input wdata, input we, output rdata, output hit);
endinterface : pims_mmd_if

//--- logic/pims_mmd_store.sv
// Purpose: storage of the indirect register spaces
// Assumes: pointer and device already latched by the bank
// Notes: unimplemented locations read zero and ignore writes
`timescale 1ns/1ps
module pims_mmd_store
  import pims_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID1 = 16'h1234, // arbitrary value
  parameter logic [15:0] VENDOR_ID2 = 16'h5678 // arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  pims_mmd_if.store mif
);
  logic [15:0] mem_r [PIMS_SLOTS]; // one word per implemented location
  logic [5:0] slot; // storage slot of the pointed location

  // maps device and index to a storage slot
  function automatic logic [5:0] pims_slot(input logic [4:0] d, input logic [15:0] i);
    logic [5:0] s;
    s = PIMS_NO_SLOT;
    if (d == PIMS_DEV_PCS) begin
      case (i)
        16'd0: s = 6'd0;
        16'd1: s = 6'd1;
        16'd5: s = 6'd2;
        16'd6: s = 6'd3;
        16'd20: s = 6'd4;
        16'd22: s = 6'd5;
        default: begin
          if (i >= 16'd32784 && i <= 16'd32786) s = 6'(i - 16'd32784) + 6'd6;
          else if (i >= 16'd32801 && i <= 16'd32808) s = 6'(i - 16'd32801) + 6'd9;
          else if (i >= 16'd32865 && i <= 16'd32868) s = 6'(i - 16'd32865) + 6'd17;
        end
      endcase
    end else if (d == PIMS_DEV_AN) begin
      case (i)
        16'd5: s = 6'd21;
        16'd6: s = 6'd22;
        16'd60: s = 6'd23;
        16'd61: s = 6'd24;
        default: s = PIMS_NO_SLOT;
      endcase
    end else if (d == PIMS_DEV_VND) begin
      case (i)
        16'd2: s = 6'd25;
        16'd3: s = 6'd26;
        16'd5: s = 6'd27;
        16'd6: s = 6'd28;
        16'd8: s = 6'd29;
        16'd11: s = 6'd30;
        16'd12: s = 6'd31;
        16'd14: s = 6'd32;
        16'd15: s = 6'd33;
        default: s = PIMS_NO_SLOT;
      endcase
    end
    return s;
  endfunction : pims_slot

  assign slot = pims_slot(mif.dev, mif.index);
  assign mif.hit = (slot != PIMS_NO_SLOT);
  assign mif.rdata = mif.hit ? mem_r[slot] : 16'h0000;

  // storage with present and identity defaults
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < PIMS_SLOTS; k++) begin
        mem_r[k] <= 16'h0000;
      end
      mem_r[2] <= PIMS_PRESENT1_RST;
      mem_r[3] <= PIMS_PRESENT2_RST;
      mem_r[21] <= PIMS_PRESENT1_RST;
      mem_r[22] <= PIMS_PRESENT2_RST;
      mem_r[25] <= VENDOR_ID1;
      mem_r[26] <= VENDOR_ID2;
      mem_r[27] <= PIMS_PRESENT1_RST;
      mem_r[28] <= PIMS_PRESENT2_RST;
    end else if (mif.we && mif.hit) begin
      mem_r[slot] <= mif.wdata;
    end
  end
endmodule : pims_mmd_store

//--- logic/pims_pkg.sv
// Purpose: shared constants for the management register bank
// Assumes: 16-bit management registers, register port fed by the serial frame engine
// Notes: indices are register numbers on the management bus
package pims_pkg;
  // register indices on the management bus
  localparam logic [4:0] PIMS_IDX_MMD_CTRL = 5'h0d;
  localparam logic [4:0] PIMS_IDX_MMD_DATA = 5'h0e;
  localparam logic [4:0] PIMS_IDX_SYM_ERR = 5'h1a;
  localparam logic [4:0] PIMS_IDX_FLAGS = 5'h1d;
  localparam logic [4:0] PIMS_IDX_MASK = 5'h1e;
  localparam logic [4:0] PIMS_IDX_SPECIAL = 5'h1f;
  // field layouts
  localparam logic [15:0] PIMS_MASK_BITS = 16'h01fe;
  localparam int PIMS_SPC_DONE_BIT = 12;
  localparam int PIMS_SPC_4B5B_BIT = 6;
  localparam int PIMS_SPC_SPEED_LSB = 2;
  localparam int PIMS_CTRL_FN_LSB = 14;
  // reset values
  localparam logic [15:0] PIMS_MASK_RST = 16'h0000;
  localparam logic PIMS_4B5B_RST = 1'b1;
  localparam logic [15:0] PIMS_CTRL_RST = 16'h0000;
  // access control function codes
  localparam logic [1:0] PIMS_FN_ADDR = 2'h0;
  localparam logic [1:0] PIMS_FN_DATA = 2'h1;
  // indirect space device numbers
  localparam logic [4:0] PIMS_DEV_PCS = 5'h03;
  localparam logic [4:0] PIMS_DEV_AN = 5'h07;
  localparam logic [4:0] PIMS_DEV_VND = 5'h1e;
  // indirect space storage
  localparam int PIMS_SLOTS = 34;
  localparam logic [5:0] PIMS_NO_SLOT = 6'h3f;
  // device-present reset values of the indirect spaces
  localparam logic [15:0] PIMS_PRESENT1_RST = 16'h0088;
  localparam logic [15:0] PIMS_PRESENT2_RST = 16'h4000;
endpackage : pims_pkg

//--- testbench/pims_bank_monitor.sv
// Purpose: port checks of the management register bank
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every instance of the bank
`timescale 1ns/1ps
module pims_bank_chk
  import pims_pkg::*;
#(
  parameter int FLAG_W = 8 // number of interrupt sources
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [FLAG_W:1] src_event,
  input wire logic aneg_done,
  input wire logic [2:0] resolved_speed_duplex_code,
  input wire logic enc_4b5b_en,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // read of the special control/status register
  sequence s_rd_spc;
    reg_rd && reg_index == PIMS_IDX_SPECIAL;
  endsequence
  a_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  a_mask_rsvd: assert property (reg_rd && reg_index == PIMS_IDX_MASK
    |=> (reg_rdata & ~PIMS_MASK_BITS) == 16'h0000) else $error("mask reserved bits set");
  a_done_bit: assert property (s_rd_spc |=> reg_rdata[12] == $past(aneg_done))
    else $error("done bit wrong");
  a_speed_code: assert property (s_rd_spc
    |=> reg_rdata[4:2] == $past(resolved_speed_duplex_code)) else $error("speed code wrong");
  a_enc_bit: assert property (s_rd_spc |=> reg_rdata[6] == enc_4b5b_en)
    else $error("encoder bit differs from output");
  a_spc_rsvd: assert property (s_rd_spc |=> (reg_rdata & 16'hefa3) == 16'h0000)
    else $error("special reserved bits set");
  // a mask write shows on irq one edge after it lands
  a_irq_cause: assert property ($rose(irq) |-> $past(|src_event) || $past(reg_wr, 2))
    else $error("interrupt without cause");
  a_irq_clear: assert property (reg_rd && reg_index == PIMS_IDX_FLAGS
    && src_event == '0 |=> !irq) else $error("interrupt kept after flag read");
endmodule : pims_bank_chk

bind pims_bank pims_bank_chk #(.FLAG_W(FLAG_W)) u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .reg_index(reg_index),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .src_event(src_event),
  .aneg_done(aneg_done),
  .resolved_speed_duplex_code(resolved_speed_duplex_code),
  .enc_4b5b_en(enc_4b5b_en),
  .irq(irq)
);

//--- testbench/pims_host.sv
// Purpose: management host driving the register port
// Assumes: requests launched at the falling edge, one-cycle pulses
// Notes: idle write data shows the inverse of the last value
`timescale 1ns/1ps
module pims_host
  import pims_pkg::*;
(
  input wire logic clk,
  output logic [4:0] reg_index,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_index = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'hffff;
  end
  // one write pulse
  task automatic wr(input logic [4:0] idx, input logic [15:0] dat);
    @(negedge clk);
    reg_index = idx;
    reg_wdata = dat;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~dat;
  endtask : wr
  // one read pulse, answer taken while the valid pulse stands
  task automatic rd(input logic [4:0] idx, output logic [15:0] dat, output logic vld);
    @(negedge clk);
    reg_index = idx;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    vld = reg_rvalid;
    dat = reg_rdata;
  endtask : rd
  task automatic mmd(input logic [4:0] dev, input logic [15:0] idx);
    wr(PIMS_IDX_MMD_CTRL, {PIMS_FN_ADDR, 9'h000, dev});
    wr(PIMS_IDX_MMD_DATA, idx);
    wr(PIMS_IDX_MMD_CTRL, {PIMS_FN_DATA, 9'h000, dev});
  endtask : mmd
endmodule : pims_host

//--- testbench/testbench.sv
// Purpose: directed register tests of the bank
// Assumes: inputs change at the falling edge
// Notes: expectations come from the register map only
`timescale 1ns/1ps
module testbench
  import pims_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] reg_index;
  logic reg_wr, reg_rd, reg_rvalid, v, b;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [8:1] src_event = 8'h00;
  logic aneg_done = 1'b0;
  logic [2:0] resolved_speed_duplex_code = 3'b001;
  logic link_100 = 1'b1;
  logic rx_in_packet = 1'b0;
  logic rx_symbol_error = 1'b0;
  logic enc_4b5b_en, irq;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [2:0] codes [4] = '{3'b001, 3'b101, 3'b010, 3'b110};
  logic [4:0] devs [3] = '{5'h03, 5'h07, 5'h1e};
  logic [15:0] widx [3] = '{16'd32808, 16'd61, 16'd12};
  always #5 clk = ~clk;
  pims_bank uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_index(reg_index),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .src_event(src_event),
    .aneg_done(aneg_done),
    .resolved_speed_duplex_code(resolved_speed_duplex_code),
    .link_100(link_100),
    .rx_in_packet(rx_in_packet),
    .rx_symbol_error(rx_symbol_error),
    .enc_4b5b_en(enc_4b5b_en),
    .irq(irq)
  );
  pims_host host (
    .clk(clk),
    .reg_index(reg_index),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read, expect the valid pulse and the value
  task automatic rchk(input logic [4:0] idx, input logic [15:0] exp);
    host.rd(idx, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask : rchk
  // one-cycle event pulse
  task automatic ev(input logic [8:1] e);
    @(negedge clk) src_event = e;
    @(negedge clk) src_event = 8'h00;
  endtask : ev
  // one packet carrying n symbol errors
  task automatic pkt(input int n);
    @(negedge clk) rx_in_packet = 1'b1;
    repeat (n) begin
      @(negedge clk) rx_symbol_error = 1'b1;
      @(negedge clk) rx_symbol_error = 1'b0;
    end
    @(negedge clk) rx_in_packet = 1'b0;
  endtask : pkt
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    rchk(PIMS_IDX_MASK, 16'h0000);
    rchk(PIMS_IDX_SPECIAL, 16'h0044);
    rchk(5'h00, 16'h0000);
    host.wr(PIMS_IDX_MASK, 16'hffff);
    rchk(PIMS_IDX_MASK, 16'h01fe);
    for (int i = 0; i < 4; i++) begin
      b = i[0];
      @(negedge clk) resolved_speed_duplex_code = codes[i];
      aneg_done = b;
      // the bench host stands for a MAC kept in MII mode
      host.wr(PIMS_IDX_SPECIAL, {16{b}});
      rchk(PIMS_IDX_SPECIAL, {3'b000, b, 5'h00, b, 1'b0, codes[i], 2'b00});
      chk({15'h0000, enc_4b5b_en}, {15'h0000, b});
    end
    $display("test special done");
    for (int n = 1; n <= 8; n++) begin
      ev(8'h01 << (n - 1));
      chk({15'h0000, irq}, 16'h0001);
      rchk(PIMS_IDX_FLAGS, 16'h0001 << n);
      chk({15'h0000, irq}, 16'h0000);
    end
    host.wr(PIMS_IDX_MASK, 16'h0000);
    ev(8'h10);
    chk({15'h0000, irq}, 16'h0000);
    rchk(PIMS_IDX_FLAGS, 16'h0020);
    // event and flag read in one cycle: the event wins
    fork
      ev(8'h80);
      rchk(PIMS_IDX_FLAGS, 16'h0000);
    join
    rchk(PIMS_IDX_FLAGS, 16'h0100);
    $display("test interrupt done");
    for (int k = 0; k < 3; k++) begin
      host.mmd(devs[k], 16'd5);
      rchk(PIMS_IDX_MMD_DATA, PIMS_PRESENT1_RST);
      host.mmd(devs[k], 16'd6);
      rchk(PIMS_IDX_MMD_DATA, PIMS_PRESENT2_RST);
      host.mmd(devs[k], widx[k]);
      host.wr(PIMS_IDX_MMD_DATA, 16'h5a5a ^ widx[k]);
      rchk(PIMS_IDX_MMD_DATA, 16'h5a5a ^ widx[k]);
    end
    host.mmd(5'h04, 16'd5);
    rchk(PIMS_IDX_MMD_CTRL, 16'h4004);
    rchk(PIMS_IDX_MMD_DATA, 16'h0000);
    host.mmd(5'h03, 16'd2);
    host.wr(PIMS_IDX_MMD_DATA, 16'h1111);
    rchk(PIMS_IDX_MMD_DATA, 16'h0000);
    host.wr(PIMS_IDX_MMD_CTRL, 16'h0003);
    host.wr(PIMS_IDX_MMD_DATA, 16'h8021);
    rchk(PIMS_IDX_MMD_DATA, 16'h8021);
    $display("test indirect done");
    pkt(2);
    rchk(PIMS_IDX_SYM_ERR, 16'h0001);
    rchk(PIMS_IDX_SYM_ERR, 16'h0001);
    pkt(1);
    @(negedge clk) link_100 = 1'b0;
    pkt(1);
    rchk(PIMS_IDX_SYM_ERR, 16'h0002);
    $display("test symbol counter done");
    // second reset in mid-run brings back the reset values
    host.wr(PIMS_IDX_MASK, 16'h0102);
    host.wr(PIMS_IDX_SPECIAL, 16'h0000);
    @(negedge clk) sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk({15'h0000, enc_4b5b_en}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rchk(PIMS_IDX_MASK, 16'h0000);
    rchk(PIMS_IDX_MMD_CTRL, 16'h0000);
    rchk(PIMS_IDX_SYM_ERR, 16'h0000);
    $display("test reset done");
    test_done();
  end
endmodule : testbench
